// >>> common/pkc_pkg.sv
// constants of the configuration block
// assumes one system clock and a synchronous active-low reset
package pkc_pkg;

    // ======
    // serial port addresses and frame shape
    localparam logic [4:0] CFG1_ADDR = 5'h00;
    localparam logic [4:0] CFG2_ADDR = 5'h01;
    localparam logic [5:0] INSTR_BITS = 6'h08;
    localparam logic [5:0] FRAME_BITS = 6'h28;
    localparam int unsigned INSTR_READ = 7;

    // ======
    // power_keying_serial_config fields
    localparam int unsigned C1_KEY_EN = 9;
    localparam int unsigned C1_KEY_AUTO = 8;
    localparam int unsigned C1_DIG_PD = 7;
    localparam int unsigned C1_DAC_PD = 6;
    localparam int unsigned C1_REF_PD = 5;
    localparam int unsigned C1_AUX_PD = 4;
    localparam int unsigned C1_EXT_PD_FAST = 3;
    localparam int unsigned C1_AUTO_PD = 2;
    localparam int unsigned C1_THREE_WIRE = 1;
    localparam int unsigned C1_LSB_FIRST = 0;
    localparam int unsigned C1_MODE_LO = 24;
    localparam int unsigned C1_MODE_HI = 25;
    localparam logic [1:0] MODE_QUAD = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;

    // ======
    // interface_update_config fields
    localparam int unsigned C2_DUAL_EN = 31;
    localparam int unsigned C2_DUAL_LSB = 30;
    localparam int unsigned C2_DUAL_EARLY = 29;
    localparam int unsigned C2_PROFILE_AMP = 24;
    localparam int unsigned C2_INT_UPDATE = 23;
    localparam int unsigned C2_SYNC_EN = 22;

    // ======
    // reset values
    localparam logic [31:0] CFG1_RESET = 32'h00000000;
    localparam logic [31:0] CFG2_RESET = 32'h00400000;

    // ======
    // timing counts
    localparam int unsigned FLUSH_CYCLES = 16;
    localparam int unsigned UPDATE_PERIOD = 64;
    localparam logic [1:0] SYNC_DIV_STEP = 2'h1;

    typedef enum logic [1:0] {PD_RUN, PD_FLUSH, PD_HALT} pkc_pd_state_t;

endpackage

// >>> design/pkc_timing.sv
// quarter-rate sync clock and the internal update strobe generator
// assumes the system clock and reset of the configuration block
module pkc_timing #(
    parameter int unsigned UPDATE_PERIOD = pkc_pkg::UPDATE_PERIOD
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sync_enable,
    input wire logic internal_update,
    output logic sync_clk,
    output logic update_pulse
);
    localparam int unsigned PW = $clog2(UPDATE_PERIOD + 1);

    logic [1:0] div_cnt;
    logic [1:0] next_div_cnt;
    logic sync_q;
    logic next_sync_q;
    logic [PW-1:0] per_cnt;
    logic [PW-1:0] next_per_cnt;
    logic pulse_q;
    logic next_pulse_q;

    // ======
    // next values
    always_comb begin
        next_div_cnt = div_cnt + pkc_pkg::SYNC_DIV_STEP;
        // low output when disabled, one quarter of the clock otherwise
        next_sync_q = sync_enable & next_div_cnt[1]; // (R17)
        next_per_cnt = per_cnt;
        next_pulse_q = 1'b0;
        // counter idles at zero so the first strobe is a full period away
        if (!internal_update) begin
            next_per_cnt = '0;
        end else if (per_cnt == PW'(UPDATE_PERIOD - 1)) begin
            next_per_cnt = '0;
            next_pulse_q = 1'b1; // (R16)
        end else begin
            next_per_cnt = per_cnt + PW'(1);
        end
    end

    // ======
    // registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_cnt <= 2'h0;
            sync_q <= 1'b0;
            per_cnt <= '0;
            pulse_q <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            sync_q <= next_sync_q;
            per_cnt <= next_per_cnt;
            pulse_q <= next_pulse_q;
        end
    end

    assign sync_clk = sync_q;
    assign update_pulse = pulse_q;
endmodule

// >>> design/pkc_config_regs.sv
// serial-programmed power, shift keying and interface configuration
// assumes serial pins and strobes are synchronous to SYS_CLK
// Function
// (R1) bit 9 enables output shift keying
// (R2) bit 8 picks auto keying, only while keying on
// (R3) bit 7 stops core clocks at once
// (R4) bit 6 powers down main converter
// (R5) bit 5 stops reference input and loop at once
// (R6) bit 4 powers down auxiliary converter
// (R7) bit 3 picks fast-recovery response to power-down pin
// (R8) bit 2: transmit enable low flushes then halts; not single tone
// (R9) bit 1 makes data pin input-only, three-wire
// (R10) bit 0 picks lsb-first serial order
// (R11) second register at address 0x01, four bytes
// (R12) bit 31 in quadrature mode enables dual port and GPIO
// (R13) bit 30 picks dual port bit order
// (R14) bit 29 picks early frame sync
// (R15) profile sets amplitude in single tone without keying
// (R16) bit 23 picks internal update strobe, at once
// (R17) bit 22 enables quarter-rate sync clock
// (R18) mode 25:24: 00 quadrature, 01 single tone, 1x interpolating
// (R19) writes stage until update, except immediate bits
module pkc_config_regs #(
    parameter int unsigned FLUSH_CYCLES = pkc_pkg::FLUSH_CYCLES,
    parameter int unsigned UPDATE_PERIOD = pkc_pkg::UPDATE_PERIOD
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SDIO_IN,
    output logic SDIO_OUT,
    output logic SDIO_OE,
    output logic SDO,
    input wire logic IO_UPDATE_IN,
    output logic IO_UPDATE_OUT,
    output logic IO_UPDATE_OE,
    output logic SYNC_CLK,
    input wire logic EXTERNAL_POWER_DOWN_PIN,
    input wire logic TRANSMIT_ENABLE_PIN,
    output logic OUTPUT_SHIFT_KEYING_ENABLE,
    output logic OUTPUT_SHIFT_KEYING_AUTO,
    output logic OUTPUT_SHIFT_KEYING_MANUAL,
    output logic DIGITAL_CORE_CLOCK_STOP,
    output logic DAC_POWER_DOWN,
    output logic REFERENCE_CLOCK_INPUT_POWER_DOWN,
    output logic AUX_DAC_POWER_DOWN,
    output logic FULL_POWER_DOWN,
    output logic FAST_RECOVERY_POWER_DOWN,
    output logic BASEBAND_FLUSH,
    output logic BASEBAND_CLOCK_HALT,
    output logic MODE_QUADRATURE,
    output logic MODE_SINGLE_TONE,
    output logic MODE_INTERPOLATING,
    output logic DUAL_SERIAL_DATA_PORT_ACTIVE,
    output logic GPIO_ENABLE,
    output logic DUAL_SERIAL_LSB_FIRST,
    output logic DUAL_SERIAL_EARLY_SYNC,
    output logic PROFILE_AMPLITUDE_SCALE,
    output logic AMPLITUDE_SCALE_BYPASS
);
    localparam int unsigned FW = $clog2(FLUSH_CYCLES + 1);

    // reverse a word so lsb-first reads shift from the top
    function automatic logic [31:0] bit_rev(input logic [31:0] w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = w[31-i];
        end
        return r;
    endfunction

    // ======
    // serial port state
    logic sclk_q;
    logic [5:0] bit_cnt;
    logic [5:0] next_bit_cnt;
    logic [7:0] instr;
    logic [7:0] next_instr;
    logic [31:0] shift_in;
    logic [31:0] next_shift_in;
    logic [31:0] shift_out;
    logic [31:0] next_shift_out;
    logic wr_commit;
    logic sclk_rise;
    logic sclk_fall;
    logic lsb_first;
    logic reading;

    assign sclk_rise = SCLK & ~sclk_q;
    assign sclk_fall = ~SCLK & sclk_q;
    assign reading = instr[pkc_pkg::INSTR_READ];

    // ======
    // configuration state
    logic [31:0] cfg1_stg;
    logic [31:0] cfg2_stg;
    logic [31:0] cfg1_act;
    logic [31:0] cfg2_act;
    logic [31:0] next_cfg1_stg;
    logic [31:0] next_cfg2_stg;
    logic [31:0] next_cfg1_act;
    logic [31:0] next_cfg2_act;
    logic upd_q;
    logic int_pulse;
    logic update;
    logic int_mode;
    logic [1:0] mode;

    assign int_mode = cfg2_act[pkc_pkg::C2_INT_UPDATE];
    assign lsb_first = cfg1_act[pkc_pkg::C1_LSB_FIRST];
    assign mode = cfg1_act[pkc_pkg::C1_MODE_HI:pkc_pkg::C1_MODE_LO];
    // external strobe acts on its rising edge, internal on its pulse
    assign update = int_mode ? int_pulse : (IO_UPDATE_IN & ~upd_q); // (R16)

    // ======
    // serial shifter: instruction byte then one 32-bit word
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_instr = instr;
        next_shift_in = shift_in;
        next_shift_out = shift_out;
        wr_commit = 1'b0;
        if (CS_N) begin
            next_bit_cnt = 6'h00;
        end else begin
            if (sclk_rise && bit_cnt < pkc_pkg::FRAME_BITS) begin
                next_bit_cnt = bit_cnt + 6'h01;
                if (bit_cnt < pkc_pkg::INSTR_BITS) begin
                    next_instr = lsb_first ? {SDIO_IN, instr[7:1]}
                                           : {instr[6:0], SDIO_IN}; // (R10)
                end else begin
                    next_shift_in = lsb_first ? {SDIO_IN, shift_in[31:1]}
                                              : {shift_in[30:0], SDIO_IN}; // (R10)
                end
                // load read data as soon as the address is known
                if (bit_cnt == pkc_pkg::INSTR_BITS - 6'h01) begin
                    case (next_instr[4:0])
                        pkc_pkg::CFG1_ADDR: next_shift_out = cfg1_act;
                        pkc_pkg::CFG2_ADDR: next_shift_out = cfg2_act; // (R11)
                        default: next_shift_out = 32'h00000000;
                    endcase
                    if (lsb_first) begin
                        next_shift_out = bit_rev(next_shift_out);
                    end
                end
                if (bit_cnt == pkc_pkg::FRAME_BITS - 6'h01 && !reading) begin
                    wr_commit = 1'b1;
                end
            end
            // first data bit is held through its rising edge, then advance
            if (sclk_fall && bit_cnt > pkc_pkg::INSTR_BITS
                    && bit_cnt < pkc_pkg::FRAME_BITS) begin
                next_shift_out = {shift_out[30:0], 1'b0};
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            sclk_q <= 1'b0;
            upd_q <= 1'b0;
            bit_cnt <= 6'h00;
            instr <= 8'h00;
            shift_in <= 32'h00000000;
            shift_out <= 32'h00000000;
        end else begin
            sclk_q <= SCLK;
            upd_q <= IO_UPDATE_IN;
            bit_cnt <= next_bit_cnt;
            instr <= next_instr;
            shift_in <= next_shift_in;
            shift_out <= next_shift_out;
        end
    end

    // ======
    // staged and active registers
    always_comb begin
        next_cfg1_stg = cfg1_stg;
        next_cfg2_stg = cfg2_stg;
        next_cfg1_act = cfg1_act;
        next_cfg2_act = cfg2_act;
        // writes land in staging; the update copies staging across
        if (wr_commit && instr[4:0] == pkc_pkg::CFG1_ADDR) begin
            next_cfg1_stg = next_shift_in; // (R19)
        end
        if (wr_commit && instr[4:0] == pkc_pkg::CFG2_ADDR) begin
            next_cfg2_stg = next_shift_in; // (R11)
        end
        if (update) begin
            next_cfg1_act = cfg1_stg; // (R19)
            next_cfg2_act = cfg2_stg;
        end
        // immediate bits bypass staging, a same-cycle write wins
        if (wr_commit && instr[4:0] == pkc_pkg::CFG1_ADDR) begin
            next_cfg1_act[pkc_pkg::C1_DIG_PD] =
                next_shift_in[pkc_pkg::C1_DIG_PD]; // (R3)
            next_cfg1_act[pkc_pkg::C1_REF_PD] =
                next_shift_in[pkc_pkg::C1_REF_PD]; // (R5)
        end
        if (wr_commit && instr[4:0] == pkc_pkg::CFG2_ADDR) begin
            next_cfg2_act[pkc_pkg::C2_INT_UPDATE] =
                next_shift_in[pkc_pkg::C2_INT_UPDATE]; // (R16)
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            cfg1_stg <= pkc_pkg::CFG1_RESET;
            cfg2_stg <= pkc_pkg::CFG2_RESET;
            cfg1_act <= pkc_pkg::CFG1_RESET;
            cfg2_act <= pkc_pkg::CFG2_RESET;
        end else begin
            cfg1_stg <= next_cfg1_stg;
            cfg2_stg <= next_cfg2_stg;
            cfg1_act <= next_cfg1_act;
            cfg2_act <= next_cfg2_act;
        end
    end

    // ======
    // transmit-enable driven flush and clock halt
    pkc_pkg::pkc_pd_state_t pd_state;
    pkc_pkg::pkc_pd_state_t next_pd_state;
    logic [FW-1:0] flush_cnt;
    logic [FW-1:0] next_flush_cnt;
    logic auto_pd;

    // ignored in single tone mode
    assign auto_pd = cfg1_act[pkc_pkg::C1_AUTO_PD]
        & (mode != pkc_pkg::MODE_SINGLE); // (R8)

    always_comb begin
        next_pd_state = pd_state;
        next_flush_cnt = flush_cnt;
        case (pd_state)
            pkc_pkg::PD_RUN: begin
                next_flush_cnt = '0;
                if (auto_pd && !TRANSMIT_ENABLE_PIN) begin
                    next_pd_state = pkc_pkg::PD_FLUSH; // (R8)
                end
            end
            pkc_pkg::PD_FLUSH: begin
                next_flush_cnt = flush_cnt + FW'(1);
                if (TRANSMIT_ENABLE_PIN || !auto_pd) begin
                    next_pd_state = pkc_pkg::PD_RUN;
                end else if (flush_cnt == FW'(FLUSH_CYCLES - 1)) begin
                    next_pd_state = pkc_pkg::PD_HALT; // (R8)
                end
            end
            pkc_pkg::PD_HALT: begin
                // clocks come back as soon as transmit enable rises
                if (TRANSMIT_ENABLE_PIN || !auto_pd) begin
                    next_pd_state = pkc_pkg::PD_RUN; // (R8)
                end
            end
            default: next_pd_state = pkc_pkg::PD_RUN;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            pd_state <= pkc_pkg::PD_RUN;
            flush_cnt <= '0;
        end else begin
            pd_state <= next_pd_state;
            flush_cnt <= next_flush_cnt;
        end
    end

    // ======
    // sync clock and internal update strobe
    pkc_timing #(
        .UPDATE_PERIOD(UPDATE_PERIOD)
    ) u_timing (
        .sys_clk(SYS_CLK),
        .resetn(RESETN),
        .sync_enable(cfg2_act[pkc_pkg::C2_SYNC_EN]), // (R17)
        .internal_update(int_mode),
        .sync_clk(SYNC_CLK),
        .update_pulse(int_pulse)
    );

    // pin turns around to an output only in internal mode
    assign IO_UPDATE_OUT = int_pulse & int_mode; // (R16)
    assign IO_UPDATE_OE = int_mode; // (R16)

    // ======
    // serial read data: data pin in two-wire, separate pin in three-wire
    logic read_phase;
    logic three_wire;

    assign read_phase = ~CS_N & reading & (bit_cnt >= pkc_pkg::INSTR_BITS)
        & (bit_cnt < pkc_pkg::FRAME_BITS);
    assign three_wire = cfg1_act[pkc_pkg::C1_THREE_WIRE];
    assign SDIO_OUT = shift_out[31];
    assign SDIO_OE = read_phase & ~three_wire; // (R9)
    assign SDO = read_phase & three_wire & shift_out[31]; // (R9)

    // ======
    // decoded controls, registered so they never glitch
    logic key_en;
    logic dual_on;
    logic single;
    logic [23:0] ctl;
    logic [23:0] next_ctl;

    assign key_en = cfg1_act[pkc_pkg::C1_KEY_EN];
    assign single = (mode == pkc_pkg::MODE_SINGLE);
    // dual port exists only in quadrature mode
    assign dual_on = cfg2_act[pkc_pkg::C2_DUAL_EN] & (mode == pkc_pkg::MODE_QUAD);

    always_comb begin
        next_ctl = '0;
        next_ctl[0] = key_en; // (R1)
        next_ctl[1] = key_en & cfg1_act[pkc_pkg::C1_KEY_AUTO]; // (R2)
        next_ctl[2] = key_en & ~cfg1_act[pkc_pkg::C1_KEY_AUTO]; // (R2)
        next_ctl[3] = next_cfg1_act[pkc_pkg::C1_DIG_PD]; // (R3)
        next_ctl[4] = cfg1_act[pkc_pkg::C1_DAC_PD]; // (R4)
        next_ctl[5] = next_cfg1_act[pkc_pkg::C1_REF_PD]; // (R5)
        next_ctl[6] = cfg1_act[pkc_pkg::C1_AUX_PD]; // (R6)
        next_ctl[7] = EXTERNAL_POWER_DOWN_PIN
            & ~cfg1_act[pkc_pkg::C1_EXT_PD_FAST]; // (R7)
        next_ctl[8] = EXTERNAL_POWER_DOWN_PIN
            & cfg1_act[pkc_pkg::C1_EXT_PD_FAST]; // (R7)
        next_ctl[9] = (next_pd_state == pkc_pkg::PD_FLUSH); // (R8)
        next_ctl[10] = (next_pd_state == pkc_pkg::PD_HALT); // (R8)
        next_ctl[11] = (mode == pkc_pkg::MODE_QUAD); // (R18)
        next_ctl[12] = single; // (R18)
        next_ctl[13] = mode[1]; // (R18)
        next_ctl[14] = dual_on; // (R12)
        next_ctl[15] = dual_on; // (R12)
        next_ctl[16] = dual_on & cfg2_act[pkc_pkg::C2_DUAL_LSB]; // (R13)
        next_ctl[17] = dual_on & cfg2_act[pkc_pkg::C2_DUAL_EARLY]; // (R14)
        next_ctl[18] = single & ~key_en & cfg2_act[pkc_pkg::C2_PROFILE_AMP]; // (R15)
        next_ctl[19] = single & ~key_en & ~cfg2_act[pkc_pkg::C2_PROFILE_AMP]; // (R15)
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            ctl <= 24'h000000;
        end else begin
            ctl <= next_ctl;
        end
    end

    assign OUTPUT_SHIFT_KEYING_ENABLE = ctl[0];
    assign OUTPUT_SHIFT_KEYING_AUTO = ctl[1];
    assign OUTPUT_SHIFT_KEYING_MANUAL = ctl[2];
    assign DIGITAL_CORE_CLOCK_STOP = ctl[3];
    assign DAC_POWER_DOWN = ctl[4];
    assign REFERENCE_CLOCK_INPUT_POWER_DOWN = ctl[5];
    assign AUX_DAC_POWER_DOWN = ctl[6];
    assign FULL_POWER_DOWN = ctl[7];
    assign FAST_RECOVERY_POWER_DOWN = ctl[8];
    assign BASEBAND_FLUSH = ctl[9];
    assign BASEBAND_CLOCK_HALT = ctl[10];
    assign MODE_QUADRATURE = ctl[11];
    assign MODE_SINGLE_TONE = ctl[12];
    assign MODE_INTERPOLATING = ctl[13];
    assign DUAL_SERIAL_DATA_PORT_ACTIVE = ctl[14];
    assign GPIO_ENABLE = ctl[15];
    assign DUAL_SERIAL_LSB_FIRST = ctl[16];
    assign DUAL_SERIAL_EARLY_SYNC = ctl[17];
    assign PROFILE_AMPLITUDE_SCALE = ctl[18];
    assign AMPLITUDE_SCALE_BYPASS = ctl[19];
endmodule

// >>> dv/pkc_host_model.sv
// host model that drives serial control port frames
// assumes SYS_CLK paced pins; read data taken from the data wire or SDO
module pkc_host_model (
    input wire logic sys_clk,
    input wire logic sdio_wire,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdio_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======
    // frame engine
    logic lsb_first = 1'b0; // bench keeps this equal to the active bit order
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdio_drv = 1'b0;
    end
    // 8 instruction bits then 32 word bits; SCLK 2 cycles high, 2 low
    task automatic frame(input logic rd, input logic [4:0] a, input logic [31:0] wd,
            input logic tw, output logic [31:0] rdat);
        logic [39:0] bits;
        logic v;
        bits = {rd, 2'h0, a, wd};
        rdat = 32'h0;
        @(negedge sys_clk);
        cs_n = 1'b0;
        for (int i = 0; i < 40; i++) begin
            // a released line toggles so a stale bit never looks valid
            if (rd && i >= 8) sdio_drv = ~sdio_drv;
            else if (lsb_first) sdio_drv = (i < 8) ? bits[32 + i] : bits[i - 8];
            else sdio_drv = bits[39 - i];
            @(negedge sys_clk);
            v = tw ? sdo : sdio_wire;
            if (i >= 8) rdat = lsb_first ? {v, rdat[31:1]} : {rdat[30:0], v};
            sclk = 1'b1;
            repeat (2) @(negedge sys_clk);
            sclk = 1'b0;
            @(negedge sys_clk);
        end
        cs_n = 1'b1;
    endtask
endmodule

// >>> dv/pkc_config_asserts.sv
// assertions watching the ports of the configuration block
// assumes binding into pkc_config_regs; one clock, synchronous low reset
module pkc_config_checker #(
    parameter int unsigned FLUSH_CYCLES = pkc_pkg::FLUSH_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic EXTERNAL_POWER_DOWN_PIN,
    input wire logic TRANSMIT_ENABLE_PIN,
    input wire logic IO_UPDATE_OUT,
    input wire logic IO_UPDATE_OE,
    input wire logic SYNC_CLK,
    input wire logic OUTPUT_SHIFT_KEYING_ENABLE,
    input wire logic OUTPUT_SHIFT_KEYING_AUTO,
    input wire logic OUTPUT_SHIFT_KEYING_MANUAL,
    input wire logic FULL_POWER_DOWN,
    input wire logic FAST_RECOVERY_POWER_DOWN,
    input wire logic BASEBAND_FLUSH,
    input wire logic BASEBAND_CLOCK_HALT,
    input wire logic MODE_QUADRATURE,
    input wire logic MODE_SINGLE_TONE,
    input wire logic MODE_INTERPOLATING,
    input wire logic DUAL_SERIAL_DATA_PORT_ACTIVE,
    input wire logic GPIO_ENABLE
);
    // ======
    // flush run length, counted so no long repetition is needed
    logic [7:0] flush_run;
    always_ff @(posedge SYS_CLK) begin
        flush_run <= (!RESETN || !BASEBAND_FLUSH) ? 8'h00 : flush_run + 8'h01;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // ======
    // properties
    key_select_a: assert property (
        OUTPUT_SHIFT_KEYING_ENABLE == (OUTPUT_SHIFT_KEYING_AUTO || OUTPUT_SHIFT_KEYING_MANUAL)
        && !(OUTPUT_SHIFT_KEYING_AUTO && OUTPUT_SHIFT_KEYING_MANUAL)) else $error("keying decode");
    mode_onehot_a: assert property ($past(RESETN) |->
        $onehot({MODE_QUADRATURE, MODE_SINGLE_TONE, MODE_INTERPOLATING})) else $error("mode");
    pd_pin_a: assert property ($past(RESETN) |->
        (FULL_POWER_DOWN || FAST_RECOVERY_POWER_DOWN) == $past(EXTERNAL_POWER_DOWN_PIN)
        && !(FULL_POWER_DOWN && FAST_RECOVERY_POWER_DOWN)) else $error("power-down pin");
    dual_gate_a: assert property (DUAL_SERIAL_DATA_PORT_ACTIVE == GPIO_ENABLE &&
        (!DUAL_SERIAL_DATA_PORT_ACTIVE || MODE_QUADRATURE)) else $error("dual port gating");
    sync_rate_a: assert property ($rose(SYNC_CLK) |-> !$past(SYNC_CLK, 2))
        else $error("sync clock low phase short");
    update_pulse_a: assert property (IO_UPDATE_OUT |-> IO_UPDATE_OE ##1 !IO_UPDATE_OUT)
        else $error("update pulse");
    flush_len_a: assert property ($rose(BASEBAND_CLOCK_HALT) |->
        flush_run == FLUSH_CYCLES && !BASEBAND_FLUSH) else $error("flush length");
    halt_release_a: assert property (BASEBAND_CLOCK_HALT && TRANSMIT_ENABLE_PIN |=>
        !BASEBAND_CLOCK_HALT && !BASEBAND_FLUSH) else $error("halt release");
    cover property ($rose(BASEBAND_CLOCK_HALT));
    cover property (IO_UPDATE_OUT);
    cover property (DUAL_SERIAL_DATA_PORT_ACTIVE && GPIO_ENABLE);
endmodule
bind pkc_config_regs pkc_config_checker #(.FLUSH_CYCLES(FLUSH_CYCLES)) chk_u (.*);

// >>> dv/tb_top.sv
// self-checking bench for the configuration block
// assumes the host model drives the serial pins and the checker is bound in
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FLUSH_CYCLES = 4;
    logic SYS_CLK = 1'b0, RESETN = 1'b0, IO_UPDATE_IN = 1'b0, host_drv;
    logic EXTERNAL_POWER_DOWN_PIN = 1'b0, TRANSMIT_ENABLE_PIN = 1'b1, SCLK, CS_N, SDIO_IN;
    logic SDIO_OUT, SDIO_OE, SDO, IO_UPDATE_OUT, IO_UPDATE_OE, SYNC_CLK, DAC_POWER_DOWN;
    logic OUTPUT_SHIFT_KEYING_ENABLE, OUTPUT_SHIFT_KEYING_AUTO, OUTPUT_SHIFT_KEYING_MANUAL;
    logic DIGITAL_CORE_CLOCK_STOP, REFERENCE_CLOCK_INPUT_POWER_DOWN, AUX_DAC_POWER_DOWN;
    logic FULL_POWER_DOWN, FAST_RECOVERY_POWER_DOWN, BASEBAND_FLUSH, BASEBAND_CLOCK_HALT;
    logic MODE_QUADRATURE, MODE_SINGLE_TONE, MODE_INTERPOLATING, GPIO_ENABLE;
    logic DUAL_SERIAL_DATA_PORT_ACTIVE, DUAL_SERIAL_LSB_FIRST, DUAL_SERIAL_EARLY_SYNC;
    logic PROFILE_AMPLITUDE_SCALE, AMPLITUDE_SCALE_BYPASS;
    logic [31:0] r;
    int n_mismatch = 0;
    int comparisons = 0;
    // ======
    // clock, data wire and instances
    always #20 SYS_CLK = ~SYS_CLK;
    assign SDIO_IN = SDIO_OE ? SDIO_OUT : host_drv; // device wins while its driver is on
    pkc_config_regs #(.FLUSH_CYCLES(FLUSH_CYCLES), .UPDATE_PERIOD(8)) dut_u (.*);
    pkc_host_model host_u (.sys_clk(SYS_CLK), .sdio_wire(SDIO_IN), .sdo(SDO), .sclk(SCLK),
        .cs_n(CS_N), .sdio_drv(host_drv));
    // ======
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // write, then optionally pulse the update pin
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic u);
        host_u.frame(1'b0, a, d, 1'b0, r);
        if (u) begin
            IO_UPDATE_IN = 1'b1;
            repeat (2) @(negedge SYS_CLK);
            IO_UPDATE_IN = 1'b0;
            repeat (2) @(negedge SYS_CLK);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic tw, input logic [31:0] exp);
        host_u.frame(1'b1, a, 32'h0, tw, r);
        chk(r, exp);
    endtask
    // bounded wait; running out ends the run
    task automatic wait_for(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 60) begin
            @(negedge SYS_CLK);
            n++;
        end
        if (s !== v) begin
            n_mismatch++;
            $display("BAD %0t wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ======
    // scenarios
    task automatic t_reset();
        chk(MODE_QUADRATURE, 1'b1);
        chk(IO_UPDATE_OE, 1'b0);
        rdc(5'h00, 1'b0, 32'h00000000);
        rdc(5'h01, 1'b0, 32'h00400000);
        rdc(5'h1F, 1'b0, 32'h00000000);
    endtask
    task automatic t_osk();
        logic [11:0] val [3] = '{12'h300, 12'h100, 12'h200};
        logic [2:0] exp [3] = '{3'h6, 3'h0, 3'h5};
        for (int i = 0; i < 3; i++) begin
            wr(5'h00, {20'h0, val[i]}, 1'b1);
            chk(OUTPUT_SHIFT_KEYING_ENABLE, exp[i][2]);
            chk({OUTPUT_SHIFT_KEYING_AUTO, OUTPUT_SHIFT_KEYING_MANUAL}, exp[i][1:0]);
        end
    endtask
    // immediate bits act at the write, the rest wait for the strobe
    task automatic t_power();
        wr(5'h00, 32'h000000A0, 1'b0);
        chk(DIGITAL_CORE_CLOCK_STOP, 1'b1);
        chk(REFERENCE_CLOCK_INPUT_POWER_DOWN, 1'b1);
        chk(OUTPUT_SHIFT_KEYING_ENABLE, 1'b1);
        wr(5'h00, 32'h00000058, 1'b0);
        chk(DIGITAL_CORE_CLOCK_STOP, 1'b0);
        chk(DAC_POWER_DOWN, 1'b0);
        EXTERNAL_POWER_DOWN_PIN = 1'b1;
        wr(5'h00, 32'h00000058, 1'b1);
        chk({DAC_POWER_DOWN, AUX_DAC_POWER_DOWN}, 2'h3);
        chk({FULL_POWER_DOWN, FAST_RECOVERY_POWER_DOWN}, 2'h1);
        wr(5'h00, 32'h00000000, 1'b1);
        chk({DAC_POWER_DOWN, AUX_DAC_POWER_DOWN}, 2'h0);
        chk({FULL_POWER_DOWN, FAST_RECOVERY_POWER_DOWN}, 2'h2);
        EXTERNAL_POWER_DOWN_PIN = 1'b0;
    endtask
    task automatic t_serial();
        wr(5'h00, 32'h00000001, 1'b1);
        host_u.lsb_first = 1'b1;
        rdc(5'h00, 1'b0, 32'h00000001);
        wr(5'h00, 32'h00000003, 1'b1);
        rdc(5'h00, 1'b1, 32'h00000003);
        wr(5'h00, 32'h00000000, 1'b1);
        host_u.lsb_first = 1'b0;
        rdc(5'h00, 1'b0, 32'h00000000);
    endtask
    task automatic t_tone();
        int n;
        wr(5'h00, 32'h00000004, 1'b1);
        TRANSMIT_ENABLE_PIN = 1'b0;
        wait_for(BASEBAND_FLUSH, 1'b1, n);
        wait_for(BASEBAND_FLUSH, 1'b0, n);
        chk(n, FLUSH_CYCLES);
        chk(BASEBAND_CLOCK_HALT, 1'b1);
        TRANSMIT_ENABLE_PIN = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        chk(BASEBAND_CLOCK_HALT, 1'b0);
        wr(5'h00, 32'h01000004, 1'b1);
        chk({MODE_SINGLE_TONE, AMPLITUDE_SCALE_BYPASS}, 2'h3);
        TRANSMIT_ENABLE_PIN = 1'b0;
        repeat (8) @(negedge SYS_CLK);
        chk({BASEBAND_FLUSH, BASEBAND_CLOCK_HALT}, 2'h0);
        TRANSMIT_ENABLE_PIN = 1'b1;
        wr(5'h01, 32'h01400000, 1'b1);
        chk(PROFILE_AMPLITUDE_SCALE, 1'b1);
        wr(5'h00, 32'h01000200, 1'b1);
        chk({PROFILE_AMPLITUDE_SCALE, AMPLITUDE_SCALE_BYPASS}, 2'h0);
        wr(5'h00, 32'h02000000, 1'b1);
        chk(MODE_INTERPOLATING, 1'b1);
    endtask
    task automatic t_port();
        int n;
        wr(5'h01, 32'hE0400000, 1'b1);
        chk(DUAL_SERIAL_DATA_PORT_ACTIVE, 1'b0);
        wr(5'h00, 32'h00000000, 1'b1);
        chk({DUAL_SERIAL_DATA_PORT_ACTIVE, GPIO_ENABLE}, 2'h3);
        chk({DUAL_SERIAL_LSB_FIRST, DUAL_SERIAL_EARLY_SYNC}, 2'h3);
        wr(5'h01, 32'h80800000, 1'b0);
        chk(IO_UPDATE_OE, 1'b1);
        wait_for(IO_UPDATE_OUT, 1'b1, n);
        repeat (3) @(negedge SYS_CLK);
        chk({DUAL_SERIAL_LSB_FIRST, DUAL_SERIAL_EARLY_SYNC}, 2'h0);
        for (int i = 0; i < 8; i++) begin
            chk(SYNC_CLK, 1'b0);
            @(negedge SYS_CLK);
        end
        rdc(5'h01, 1'b0, 32'h80800000);
    endtask
    // ======
    // main sequence
    initial begin
        repeat (8) @(negedge SYS_CLK);
        RESETN = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        t_reset();
        t_osk();
        t_power();
        t_serial();
        t_tone();
        t_port();
        complete_run();
    end
endmodule
